// ### rtl/usli_uart_line.v
// Purpose: serial line side of a uart: framing, fifos, flow control, rs-485 direction
// Assumes: single clk, baud divisor gives a 16x tick enable, control bits are plain ports
// Notes:   line pins pass two flip-flops; test mode repeats the last character
// Summary of operation
// - tx pin active low normally, inverted (active high) in infrared mode
// - infrared mode when infrared_enable_pin high or software ir bit set
// - rx idles at 1 normally, at 0 in infrared mode
// - auto rts only starts after rts was asserted by modem control bit
// - auto cts halts transmission while cts deasserted, resumes when asserted
// - rts, cts, dtr, dsr, cd, ri usable as general purpose i/o
// - bus_mode_select low selects pc decoding mode, high plain cpu bus
// - direction pin is general output unless efr bit 4 and feature control bit 3 are both set
// - rs-485 direction pin high when receiving, low when transmitting
// - switch to receive only after last stop bit leaves shift register
// - loading a new transmit byte in receive state returns to transmit
// - rs-485 direction off after reset, needs efr bit 4 and feature_control_reg bit 3
// - reset returns pins, fifo pointers and state machines to defaults; configuration comes in on ports, not reset here
// - test mode only when chip select, read and write all asserted
// - transmitter adds start bit before data and stop bits after
// - parity appended on transmit and checked on receive when enabled
// - separate 128-byte transmit and receive fifos
// - receiver oversamples at sixteen times the data rate
// - pc mode offers open-source interrupt output for wire-or
`timescale 1ns/1ps
`include "usli_consts.vh"
module usli_uart_line #(
    parameter FIFO_DEPTH = `USLI_FIFO_DEPTH,
    parameter FIFO_AW    = `USLI_FIFO_AW
) (
    // clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // configuration
    input  wire [15:0] baud_div,
    input  wire [1:0]  word_len_sel,
    input  wire        two_stop,
    input  wire        parity_en,
    input  wire        parity_even,
    input  wire        ir_soft_en,
    input  wire [7:0]  enhanced_feature_reg,
    input  wire [7:0]  feature_control_reg,
    input  wire [7:0]  modem_control_reg,
    input  wire        irq_pending,
    // host strobes
    input  wire        chip_select_n,
    input  wire        read_strobe_n,
    input  wire        write_strobe_n,
    input  wire        bus_mode_select,
    // transmit data in
    input  wire        tx_valid,
    input  wire [7:0]  tx_data,
    output reg         tx_ready,
    // receive data out
    output reg         rx_valid,
    output reg  [7:0]  rx_data,
    output reg         rx_parity_err,
    output reg         rx_frame_err,
    output reg         rx_break,
    input  wire        rx_pop,
    // status
    output reg         pc_mode,
    output reg         test_mode,
    output reg  [3:0]  modem_in_status,
    output reg         tx_idle,
    // line pins
    input  wire        infrared_enable_pin,
    input  wire        serial_in,
    output reg         serial_out,
    output reg         rts_pin_n,
    output reg         dtr_pin_n,
    input  wire        cts_pin_n,
    input  wire        dsr_pin_n,
    input  wire        cd_pin_n,
    input  wire        ri_pin_n,
    output reg         direction_output_pin,
    output reg         irq_out,
    output reg         irq_oe
);
    localparam TX_IDLE  = 2'd0;
    localparam TX_SHIFT = 2'd1;
    localparam RX_IDLE  = 2'd0;
    localparam RX_START = 2'd1;
    localparam RX_SHIFT = 2'd2;

    // two-flop synchronisers for all pins from outside
    reg [7:0] sync1_reg;
    reg [7:0] sync2_reg;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // infrared pin bit rests low: a high default would flip tx to 0 after reset
            sync1_reg <= 8'hfb;
            sync2_reg <= 8'hfb;
        end else begin
            sync1_reg <= {read_strobe_n, write_strobe_n, chip_select_n, bus_mode_select,
                          cts_pin_n, infrared_enable_pin, dsr_pin_n, serial_in};
            sync2_reg <= sync1_reg;
        end
    end
    wire s_rx   = sync2_reg[0];
    wire s_dsr  = sync2_reg[1];
    wire s_infrared_enable_pin = sync2_reg[2];
    wire s_cts  = sync2_reg[3];
    wire s_sel  = sync2_reg[4];
    wire s_cs   = sync2_reg[5];
    wire s_wr   = sync2_reg[6];
    wire s_rd   = sync2_reg[7];
    reg  [2:0] sync3a_reg;
    reg  [2:0] sync3b_reg;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync3a_reg <= 3'h7;
            sync3b_reg <= 3'h7;
        end else begin
            sync3a_reg <= {ri_pin_n, cd_pin_n, 1'b1};
            sync3b_reg <= sync3a_reg;
        end
    end

    wire ir_mode = s_infrared_enable_pin | ir_soft_en;
    wire rx_line = ir_mode ? ~s_rx : s_rx;
    wire auto_rts = enhanced_feature_reg[`USLI_EFR_AUTORTS_BIT];
    wire auto_cts = enhanced_feature_reg[`USLI_EFR_AUTOCTS_BIT];
    wire rs485_on = enhanced_feature_reg[`USLI_EFR_RS485_BIT]
                  & feature_control_reg[`USLI_FEATURE_CONTROL_REG_RS485_BIT];
    wire [3:0] nbits = {2'b00, word_len_sel} + 4'd5;

    // 16x tick divider
    reg [15:0] div_reg;
    reg        tick_reg;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg  <= 16'h0000;
            tick_reg <= 1'b0;
        end else if (div_reg >= baud_div - 16'h0001) begin
            div_reg  <= 16'h0000;
            tick_reg <= 1'b1;
        end else begin
            div_reg  <= div_reg + 16'h0001;
            tick_reg <= 1'b0;
        end
    end

    // fifos: flop storage, one per direction
    reg [7:0]  txf_mem [0:FIFO_DEPTH-1];
    reg [10:0] rxf_mem [0:FIFO_DEPTH-1];
    reg [FIFO_AW:0] txf_wr_reg, txf_rd_reg, rxf_wr_reg, rxf_rd_reg;
    wire txf_empty = (txf_wr_reg == txf_rd_reg);
    wire txf_full  = (txf_wr_reg - txf_rd_reg) == FIFO_DEPTH[FIFO_AW:0];
    wire rxf_empty = (rxf_wr_reg == rxf_rd_reg);
    wire rxf_full  = (rxf_wr_reg - rxf_rd_reg) == FIFO_DEPTH[FIFO_AW:0];
    wire txf_push  = tx_valid & tx_ready;

    // transmitter
    reg [1:0]  txs_reg;
    reg [11:0] txsh_reg;
    reg [3:0]  txcnt_reg, txtick_reg;
    reg [7:0]  last_char_reg;
    wire cts_ok = !auto_cts || !s_cts;
    wire tx_have = !txf_empty || test_mode;
    wire [7:0] tx_char = test_mode ? last_char_reg : txf_mem[txf_rd_reg[FIFO_AW-1:0]];
    wire tx_par = ^(tx_char & ((8'h01 << nbits) - 8'h01)) ^ ~parity_even;
    wire [3:0] tx_total = nbits + {3'b000, parity_en} + {3'b000, two_stop} + 4'd2;
    reg [11:0] tx_frame;
    always @* begin
        tx_frame = 12'hfff;
        tx_frame[0] = 1'b0;
        tx_frame[8:1] = tx_char | ~((8'h01 << nbits) - 8'h01);
        if (parity_en) begin
            tx_frame[nbits+4'd1] = tx_par;
        end
    end
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txs_reg <= TX_IDLE;
            txsh_reg <= 12'hfff;
            txcnt_reg <= 4'h0;
            txtick_reg <= 4'h0;
            txf_rd_reg <= {(FIFO_AW+1){1'b0}};
            last_char_reg <= 8'h00;
        end else begin
            case (txs_reg)
                TX_IDLE: begin
                    if (tick_reg && tx_have && cts_ok) begin
                        txsh_reg <= tx_frame;
                        txcnt_reg <= tx_total;
                        txtick_reg <= 4'h0;
                        txs_reg <= TX_SHIFT;
                        last_char_reg <= tx_char;
                        if (!test_mode) begin
                            txf_rd_reg <= txf_rd_reg + 1'b1;
                        end
                    end
                end
                default: begin
                    if (tick_reg) begin
                        txtick_reg <= txtick_reg + 4'h1;
                        if (txtick_reg == 4'hf) begin
                            txsh_reg <= {1'b1, txsh_reg[11:1]};
                            txcnt_reg <= txcnt_reg - 4'h1;
                            if (txcnt_reg == 4'h1) begin
                                txs_reg <= TX_IDLE;
                            end
                        end
                    end
                end
            endcase
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txf_wr_reg <= {(FIFO_AW+1){1'b0}};
            tx_ready <= 1'b0;
        end else begin
            if (txf_push) begin
                txf_mem[txf_wr_reg[FIFO_AW-1:0]] <= tx_data;
                txf_wr_reg <= txf_wr_reg + 1'b1;
            end
            tx_ready <= !txf_full && !(txf_push && (txf_wr_reg - txf_rd_reg)
                        == FIFO_DEPTH[FIFO_AW:0] - 1'b1);
        end
    end

    // receiver
    reg [1:0]  rxs_reg;
    reg [3:0]  rxtick_reg, rxcnt_reg;
    reg [9:0]  rxsh_reg;
    wire [3:0] rx_total = nbits + {3'b000, parity_en} + 4'd1;
    wire [9:0] rx_full_sh = {rx_line, rxsh_reg[9:1]};
    wire [9:0] rx_al = rx_full_sh >> (4'd10 - rx_total);
    wire [7:0] rx_dat = rx_al[7:0] & ((8'h01 << nbits) - 8'h01);
    wire rx_pbit = rx_al[nbits];
    wire rx_perr = parity_en && ((^rx_dat ^ rx_pbit) != ~parity_even);
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rxs_reg <= RX_IDLE;
            rxtick_reg <= 4'h0;
            rxcnt_reg <= 4'h0;
            rxsh_reg <= 10'h000;
            rxf_wr_reg <= {(FIFO_AW+1){1'b0}};
        end else if (tick_reg) begin
            case (rxs_reg)
                RX_IDLE: begin
                    rxtick_reg <= 4'h0;
                    if (!rx_line) begin
                        rxs_reg <= RX_START;
                    end
                end
                RX_START: begin
                    rxtick_reg <= rxtick_reg + 4'h1;
                    if (rxtick_reg == `USLI_MIDBIT - 2) begin
                        rxtick_reg <= 4'h0;
                        rxcnt_reg <= 4'h0;
                        rxs_reg <= rx_line ? RX_IDLE : RX_SHIFT;
                    end
                end
                RX_SHIFT: begin
                    rxtick_reg <= rxtick_reg + 4'h1;
                    if (rxtick_reg == 4'hf) begin
                        rxcnt_reg <= rxcnt_reg + 4'h1;
                        // store on the stop-bit sample itself, so data bit 0 lands at bit 0
                        if (rxcnt_reg == rx_total - 4'd1) begin
                            rxs_reg <= RX_IDLE;
                            if (!rxf_full) begin
                                rxf_mem[rxf_wr_reg[FIFO_AW-1:0]] <=
                                    {(rx_al == 10'h000) && !rx_line, !rx_line, rx_perr, rx_dat};
                                rxf_wr_reg <= rxf_wr_reg + 1'b1;
                            end
                        end else begin
                            rxsh_reg <= rx_full_sh;
                        end
                    end
                end
                default: rxs_reg <= RX_IDLE;
            endcase
        end
    end

    wire [10:0] rx_head = rxf_mem[rxf_rd_reg[FIFO_AW-1:0]];
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rxf_rd_reg <= {(FIFO_AW+1){1'b0}};
            rx_valid <= 1'b0;
            rx_data <= 8'h00;
            rx_parity_err <= 1'b0;
            rx_frame_err <= 1'b0;
            rx_break <= 1'b0;
        end else begin
            if (rx_pop && rx_valid) begin
                rxf_rd_reg <= rxf_rd_reg + 1'b1;
                rx_valid <= 1'b0;
            end else if (!rxf_empty) begin
                rx_valid <= 1'b1;
                {rx_break, rx_frame_err, rx_parity_err, rx_data} <= rx_head;
            end
        end
    end

    // flow control, rs-485 direction, gpio, bus mode, test mode
    reg rts_armed_reg;
    reg dir_tx_reg;
    wire rxf_high = (rxf_wr_reg - rxf_rd_reg) >= FIFO_DEPTH[FIFO_AW:0] - 8'd16;
    wire test_cond = !s_cs && !s_rd && !s_wr;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rts_armed_reg <= 1'b0;
            dir_tx_reg <= 1'b0;
            serial_out <= 1'b1;
            rts_pin_n <= 1'b1;
            dtr_pin_n <= 1'b1;
            direction_output_pin <= 1'b1;
            pc_mode <= 1'b0;
            test_mode <= 1'b0;
            modem_in_status <= 4'h0;
            tx_idle <= 1'b1;
            irq_out <= 1'b0;
            irq_oe <= 1'b0;
        end else begin
            serial_out <= ir_mode ? ~txsh_reg[0] : txsh_reg[0];
            if (modem_control_reg[`USLI_MCR_RTS_BIT]) begin
                rts_armed_reg <= 1'b1;
            end else begin
                rts_armed_reg <= 1'b0;
            end
            if (auto_rts && rts_armed_reg) begin
                rts_pin_n <= rxf_high;
            end else begin
                rts_pin_n <= ~modem_control_reg[`USLI_MCR_RTS_BIT];
            end
            dtr_pin_n <= ~modem_control_reg[`USLI_MCR_DTR_BIT];
            modem_in_status <= ~{sync3b_reg[2], sync3b_reg[1], s_dsr, s_cts};
            if (txf_push || txs_reg == TX_SHIFT || !txf_empty) begin
                dir_tx_reg <= 1'b1;
            end else if (txs_reg == TX_IDLE) begin
                dir_tx_reg <= 1'b0;
            end
            if (rs485_on) begin
                direction_output_pin <= ~dir_tx_reg;
            end else begin
                direction_output_pin <= ~modem_control_reg[`USLI_MCR_OP1_BIT];
            end
            tx_idle <= txf_empty && txs_reg == TX_IDLE;
            pc_mode <= !s_sel;
            if (test_cond) begin
                test_mode <= 1'b1;
            end else if (s_rd || s_wr) begin
                test_mode <= 1'b0;
            end
            // open-source output: drives high only, wire-or by external pull-down
            irq_out <= 1'b1;
            irq_oe <= !s_sel ? (irq_pending && modem_control_reg[`USLI_MCR_IRQEN_BIT])
                             : irq_pending;
        end
    end
endmodule

// ### shared/usli_consts.vh
// Purpose: constants for the serial line interface block
// Assumes: 200 MHz clk
// Notes:   bit positions refer to the control port vectors of the top module
`ifndef USLI_CONSTS_VH
`define USLI_CONSTS_VH
`define USLI_EFR_RS485_BIT     4
`define USLI_EFR_AUTORTS_BIT   6
`define USLI_EFR_AUTOCTS_BIT   7
`define USLI_FEATURE_CONTROL_REG_RS485_BIT    3
`define USLI_MCR_DTR_BIT       0
`define USLI_MCR_RTS_BIT       1
`define USLI_MCR_OP1_BIT       2
`define USLI_MCR_IRQEN_BIT     3
`define USLI_CFG_RST           8'h00
`define USLI_OVERSAMPLE        16
`define USLI_MIDBIT            8
`define USLI_DIV_DEFAULT       16'h006c
`define USLI_FIFO_DEPTH        128
`define USLI_FIFO_AW           7
`endif

// ### verif/usli_far_end.sv
// Purpose: far-end line transceiver model for the serial line block
// Assumes: one bit lasts BIT_CYC clk cycles
// Notes:   ir_mode flips both line directions
`timescale 1ns/1ps
module usli_far_end #(
    parameter BIT_CYC = 16
) (
    // clock and mode
    input  wire clk,
    input  wire ir_mode,
    // line
    input  wire line_from_dut,
    output wire line_to_dut
);
    logic drive_bit = 1'b1;
    // a released line rests at the idle level of the mode in force
    assign line_to_dut = drive_bit ^ ir_mode;
    task automatic send(input logic [11:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            drive_bit = bits[i];
            repeat (BIT_CYC) @(posedge clk);
            #1;
        end
        drive_bit = 1'b1;
    endtask
    // returns at mid-point of the last bit, so callers still see that bit
    task automatic grab(input int n, output logic [11:0] bits);
        int k;
        bits = 12'hfff;
        k = 0;
        while ((line_from_dut ^ ir_mode) && k < 5000) begin
            @(posedge clk);
            k++;
        end
        for (int i = 0; i < n; i++) begin
            repeat (i == 0 ? BIT_CYC / 2 : BIT_CYC) @(posedge clk);
            bits[i] = line_from_dut ^ ir_mode;
        end
        #1;
    endtask
endmodule

// ### verif/usli_line_props_props.sv
// Purpose: port-level checks for the serial line block
// Assumes: one clock domain, rst_n asynchronous active low
// Notes:   age_reg hides settling of synchronised inputs after reset
`timescale 1ns/1ps
module usli_line_props (
    // clock, reset and controls
    input wire       clk,
    input wire       rst_n,
    input wire [7:0] enhanced_feature_reg,
    input wire [7:0] feature_control_reg,
    input wire [7:0] modem_control_reg,
    input wire       ir_soft_en,
    input wire       infrared_enable_pin,
    input wire       chip_select_n,
    input wire       bus_mode_select,
    input wire       cts_pin_n,
    input wire       tx_valid,
    // outputs watched
    input wire       tx_idle,
    input wire       pc_mode,
    input wire       test_mode,
    input wire       serial_out,
    input wire       rts_pin_n,
    input wire       dtr_pin_n,
    input wire       direction_output_pin
);
    logic [3:0] age_reg;
    wire        rs485_on = enhanced_feature_reg[4] && feature_control_reg[3];
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            age_reg <= 4'h0;
        else if (age_reg != 4'hf)
            age_reg <= age_reg + 4'h1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_reset_pins_idle: assert property (
        $rose(rst_n) |-> serial_out && rts_pin_n && direction_output_pin && !test_mode)
        else $error("pins not at rest after reset");
    a_cs_blocks_test: assert property (chip_select_n [*4] |-> !$rose(test_mode))
        else $error("test mode without chip select");
    a_gpo_modem_pins: assert property (
        (age_reg > 4'h2 && !enhanced_feature_reg[6] && $stable(modem_control_reg))[*2]
        |-> rts_pin_n == !modem_control_reg[1] && dtr_pin_n == !modem_control_reg[0])
        else $error("modem outputs not following control");
    a_gpo_direction: assert property (
        (age_reg > 4'h2 && !feature_control_reg[3] && $stable(modem_control_reg))[*2]
        |-> direction_output_pin == !modem_control_reg[2])
        else $error("direction pin not general output");
    a_cts_halts_tx: assert property (
        (enhanced_feature_reg[7] && cts_pin_n && tx_idle)[*4] |=> $stable(serial_out))
        else $error("transmit started while cts off");
    a_idle_polarity: assert property (
        (age_reg > 4'h4 && tx_idle && !test_mode
         && $stable({ir_soft_en, infrared_enable_pin}))[*4]
        |-> serial_out == !(ir_soft_en || infrared_enable_pin))
        else $error("idle transmit level wrong");
    a_pc_mode_follows: assert property (
        (age_reg > 4'h4 && $stable(bus_mode_select))[*4] |-> pc_mode == !bus_mode_select)
        else $error("bus mode not followed");
    a_dir_rx_idle: assert property (
        (rs485_on && tx_idle && !tx_valid)[*4] |-> direction_output_pin)
        else $error("direction not receive when idle");
endmodule

// ### verif/tb_top.sv
// Purpose: self-checking bench for the serial line block
// Assumes: baud_div of 1, so one bit lasts 16 clk cycles
// Notes:   each scenario task drives and judges on its own
`timescale 1ns/1ps
module tb_top;
    localparam int BIT = 16;
    localparam logic [12:0] TXCFG [4] = '{13'h1ea5, 13'h0516, 13'h103c, 13'h1981};
    logic        clk = 1'b0, rst_n = 1'b0, two_stop = 1'b0, parity_en = 1'b0;
    logic [15:0] baud_div = 16'h0001;
    logic [1:0]  word_len_sel = 2'h3;
    logic        parity_even = 1'b0, ir_soft_en = 1'b0, irq_pending = 1'b0;
    logic [7:0]  enhanced_feature_reg = 8'h00, feature_control_reg = 8'h00;
    logic [7:0]  modem_control_reg = 8'h00, tx_data = 8'h00, rx_data;
    logic        chip_select_n = 1'b1, read_strobe_n = 1'b1, write_strobe_n = 1'b1;
    logic        bus_mode_select = 1'b1, tx_valid = 1'b0, rx_pop = 1'b0;
    logic        cts_pin_n = 1'b0, dsr_pin_n = 1'b1, cd_pin_n = 1'b1, ri_pin_n = 1'b1;
    logic        infrared_enable_pin = 1'b0, tx_ready, rx_valid, rx_parity_err;
    logic        rx_frame_err, rx_break, pc_mode, test_mode, tx_idle, serial_out;
    logic        rts_pin_n, dtr_pin_n, direction_output_pin, irq_out, irq_oe;
    logic [3:0]  modem_in_status;
    wire         serial_in;
    wire         ir_line = ir_soft_en | infrared_enable_pin;
    int          miscompares = 0, comparisons = 0, cycles = 0, nb;

    usli_uart_line dut (.*);
    usli_far_end #(.BIT_CYC(BIT)) far (.clk(clk), .ir_mode(ir_line),
        .line_from_dut(serial_out), .line_to_dut(serial_in));

    initial forever #2.5 clk = ~clk;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // start bit, data lsb first, optional parity, stop bits; n counts them all
    function automatic logic [11:0] frame(input logic [7:0] d, output int n);
        int wl;
        logic [11:0] f;
        wl = 5 + word_len_sel;
        f = 12'hffe;
        for (int i = 0; i < wl; i++) f[1+i] = d[i];
        n = wl + 2 + two_stop;
        if (parity_en) begin
            f[wl+1] = ^(d & ((8'h01 << wl) - 8'h01)) ^ !parity_even;
            n++;
        end
        return f;
    endfunction
    task automatic push(input logic [7:0] d);
        while (tx_ready !== 1'b1) step();
        tx_data = d;
        tx_valid = 1'b1;
        step();
        tx_valid = 1'b0;
    endtask
    task automatic tx_one(input logic [7:0] d);
        logic [11:0] got, e;
        int n;
        e = frame(d, n);
        push(d);
        far.grab(n, got);
        check(got, e);
    endtask
    task automatic pop();
        rx_pop = 1'b1;
        step();
        rx_pop = 1'b0;
        step();
    endtask
    task automatic drain();
        while (rx_valid === 1'b1) pop();
    endtask
    task automatic rx_one(input logic [11:0] f, input logic [7:0] d, input logic [2:0] st);
        int k;
        k = 0;
        void'(frame(d, nb));
        far.send(f, nb);
        while (rx_valid !== 1'b1 && k < 3 * BIT) begin
            step();
            k++;
        end
        check({rx_break, rx_frame_err, rx_parity_err, rx_data}, {st, d});
        pop();
    endtask
    task automatic t_tx_formats();
        for (int i = 0; i < 4; i++) begin
            {word_len_sel, parity_en, parity_even, two_stop} = TXCFG[i][12:8];
            step();
            tx_one(TXCFG[i][7:0]);
        end
        {word_len_sel, parity_en, parity_even, two_stop} = 5'b11110;
        step(2 * BIT);
    endtask
    task automatic t_rx_frames();
        drain();
        rx_one(frame(8'h6b, nb), 8'h6b, 3'b000);
        rx_one(frame(8'h6b, nb) ^ 12'h200, 8'h6b, 3'b001);
        rx_one(12'h000, 8'h00, 3'b110);
    endtask
    task automatic t_ir_modes();
        ir_soft_en = 1'b1;
        step(12 * BIT);
        drain();
        tx_one(8'h5c);
        rx_one(frame(8'h39, nb), 8'h39, 3'b000);
        ir_soft_en = 1'b0;
        infrared_enable_pin = 1'b1;
        step(12 * BIT);
        drain();
        tx_one(8'hc3);
        infrared_enable_pin = 1'b0;
        step(12 * BIT);
        drain();
    endtask
    task automatic t_cts_flow();
        logic [11:0] got;
        enhanced_feature_reg = 8'h80;
        cts_pin_n = 1'b1;
        step(4);
        push(8'h96);
        repeat (3 * BIT) begin
            step();
            check(serial_out, 1'b1);
        end
        cts_pin_n = 1'b0;
        far.grab(11, got);
        check(got, frame(8'h96, nb));
        enhanced_feature_reg = 8'h00;
        step(2 * BIT);
    endtask
    task automatic t_rs485_dir();
        logic [11:0] got;
        modem_control_reg = 8'h04;
        step(4);
        check(direction_output_pin, 1'b0);
        enhanced_feature_reg = 8'h10;
        feature_control_reg = 8'h08;
        step(4);
        check(direction_output_pin, 1'b1);
        tx_data = 8'h4e;
        tx_valid = 1'b1;
        step();
        tx_data = 8'hb1;
        step();
        tx_valid = 1'b0;
        step(2);
        check(direction_output_pin, 1'b0);
        far.grab(11, got);
        check(direction_output_pin, 1'b0);
        far.grab(11, got);
        check({got, direction_output_pin}, {frame(8'hb1, nb), 1'b0});
        step(BIT);
        check(direction_output_pin, 1'b1);
        {enhanced_feature_reg, feature_control_reg, modem_control_reg} = 24'h0;
    endtask
    task automatic t_gpio();
        for (int v = 0; v < 16; v++) begin
            modem_control_reg = {4'h0, v[3:0]};
            {ri_pin_n, cd_pin_n, dsr_pin_n, cts_pin_n} = 4'hf ^ v[3:0];
            step(4);
            check({rts_pin_n, dtr_pin_n, direction_output_pin}, 3'h7 ^ {v[1:0], v[2]});
            check(modem_in_status, v[3:0]);
        end
        {ri_pin_n, cd_pin_n, dsr_pin_n, cts_pin_n} = 4'he;
        modem_control_reg = 8'h00;
        enhanced_feature_reg = 8'h40;
        step(4);
        check(rts_pin_n, 1'b1);
        modem_control_reg = 8'h02;
        step(4);
        check(rts_pin_n, 1'b0);
        {enhanced_feature_reg, modem_control_reg} = 16'h0;
    endtask
    task automatic t_host_pins();
        bus_mode_select = 1'b0;
        irq_pending = 1'b1;
        modem_control_reg = 8'h08;
        step(5);
        check({pc_mode, irq_oe, irq_out}, 3'b111);
        modem_control_reg = 8'h00;
        step(5);
        check(irq_oe, 1'b0);
        bus_mode_select = 1'b1;
        irq_pending = 1'b0;
        read_strobe_n = 1'b0;
        write_strobe_n = 1'b0;
        step(5);
        check({pc_mode, test_mode}, 2'b00);
        chip_select_n = 1'b0;
        step(5);
        check(test_mode, 1'b1);
    endtask
    task automatic final_report();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            final_report();
        end
    end
    initial begin
        step(12);
        check({serial_out, direction_output_pin, rts_pin_n, dtr_pin_n, test_mode, irq_oe,
               tx_idle}, 7'b1111001);
        rst_n = 1'b1;
        step(2);
        check(tx_ready, 1'b1);
        t_tx_formats();
        t_rx_frames();
        t_ir_modes();
        t_cts_flow();
        t_rs485_dir();
        t_gpio();
        t_host_pins();
        final_report();
    end
endmodule
bind usli_uart_line usli_line_props props (.*);
